// >>> hw/clk_sel_defines.vh
// Function
// - System clock comes from fast clock or sub clock per three-bit select field.
// - Fast clock comes from crystal or fast RC per fast source select bit.
// - Crystal runs only when crystal enable and radio power-up are both set.
// - Crystal halve bit divides crystal frequency by two for fast clock use; radio clock stays undivided.
// - Sub clock comes only from the slow RC oscillator, nominally 32kHz.
// - Divided fast clocks, ratios two up to 64, are system clock choices.
// - On sub clock, fast oscillator stops or keeps running per its enable bit.
// - In deep sleep, time base 0 runs from slow RC clock per watchdog enable.
// - One fast and one slow oscillator always selected; in deep sleep with watchdog enable clear no oscillator runs.
// - Fast RC gives fixed 8MHz; crystal runs at 16MHz.
// - Oscillator clocks also feed radio, watchdog and time base logic.
// - Crystal is the radio clock source as well as a fast source.
// - Select 000 undivided, 001 to 110 divide 2 to 64, 111 sub clock.
// - Fast source select 0 picks fast RC, 1 picks crystal while the crystal runs, else fast RC.
// - Fast idle enable decides if fast oscillator runs while CPU halted.
`ifndef CLK_SEL_DEFINES_VH
`define CLK_SEL_DEFINES_VH

// ************************************************
// Timing
// ************************************************
`define REF_CLK_KHZ       100000
`define XTAL_FREQ_KHZ     16000
`define FAST_RC_FREQ_KHZ  8000
`define SLOW_RC_FREQ_KHZ  32
// Tick periods in reference cycles, sized to the tick counter
`define XTAL_TICK_CYC     12'h006
`define FAST_RC_TICK_CYC  12'h00C
`define SLOW_RC_TICK_CYC  12'hC35

// ************************************************
// Register offsets
// ************************************************
`define ADDR_SYS_CLK_CTRL 8'h00
`define ADDR_XTAL_CTRL    8'h01
`define ADDR_CLK_STATUS   8'h02

// ************************************************
// Fields and reset values
// ************************************************
`define SCC_SEL_MSB       7
`define SCC_SEL_LSB       5
`define SCC_SRC_BIT       3
`define SCC_FIDLE_BIT     1
`define SCC_SIDLE_BIT     0
`define SCC_RESET         8'h20
`define SCC_WMASK         8'hEF
`define XC_EN_BIT         0
`define XC_RADIO_BIT      1
`define XC_HALVE_BIT      2
`define XC_FKEEP_BIT      3
`define XC_RESET          8'h00
`define XC_WMASK          8'h0F
`define SEL_FAST          3'h0
`define SEL_SUB           3'h7

`endif

// >>> hw/system_clock_source_select.v
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "clk_sel_defines.vh"

// ************************************************
// Oscillator tick generator
// ************************************************
module osc_tick #(
	parameter [11:0] DIV = 12'h0001
) (
	input  wire clk,
	input  wire rstN,
	input  wire run,
	output reg  tick_r
);
	reg [11:0] cnt_r;

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_r  <= 12'h000;
			tick_r <= 1'b0;
		end else if (!run) begin
			cnt_r  <= 12'h000;
			tick_r <= 1'b0;
		end else if (cnt_r == DIV - 12'h001) begin
			cnt_r  <= 12'h000;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 12'h001;
			tick_r <= 1'b0;
		end
	end
endmodule

// ************************************************
// System clock source select
// ************************************************
module system_clock_source_select (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrStrobe,
	input  wire       regRdStrobe,
	output wire [7:0] regRdData,
	input  wire       cpuHalt,
	input  wire       deepSleep,
	input  wire       wdtEnable,
	output wire       sysClkEn,
	output wire       fastClkEn,
	output wire       subClkEn,
	output wire       slowRcClkEn,
	output wire       radioClkEn,
	output wire       wdtClkEn,
	output wire       timeBase0ClkEn,
	output wire       crystalOscRun,
	output wire       fastRcOscRun,
	output wire       slowRcOscRun,
	output wire       clkSwitchBusy
);
	// ************************************************
	// Declarations
	// ************************************************
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_DRAIN = 2'h1;
	localparam [1:0] ST_FILL  = 2'h2;

	localparam [11:0] XTAL_DIV = `XTAL_TICK_CYC;
	localparam [11:0] RC_DIV   = `FAST_RC_TICK_CYC;
	localparam [11:0] SLOW_DIV = `SLOW_RC_TICK_CYC;

	reg  [7:0] sccReg_r;
	reg  [7:0] xtalReg_r;
	reg  [7:0] rdData_r;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg  [2:0] curSel_r;
	reg        curSrc_r;
	reg  [5:0] divCnt_r;
	reg        halfPh_r;
	reg        xtalRun_r;
	reg        fastRun_r;
	reg        slowRun_r;
	reg        sysClkEn_r;
	reg        fastClkEn_r;
	reg        subClkEn_r;
	reg        slowRcClkEn_r;
	reg        radioClkEn_r;
	reg        wdtClkEn_r;
	reg        timeBase0ClkEn_r;
	reg        switchBusy_r;

	wire       xtalTick;
	wire       rcTick;
	wire       slowTick;
	wire [2:0] tgtSel;
	wire       tgtSrc;
	wire       xtalEff;
	wire       rawFastCur;
	wire       rawFastTgt;
	wire       subOn;
	wire       subTick;
	wire [5:0] curMask;
	wire       sysTick;
	wire       tgtRaw;
	wire       curLost;
	wire       adopt;
	wire       busy;
	wire       fastUse;
	wire       xtalRun_nxt;
	wire       fastRun_nxt;
	wire       slowRun_nxt;

	// Divide mask per select code
	function [5:0] selMask;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    selMask = 6'h00;
				3'h1:    selMask = 6'h01;
				3'h2:    selMask = 6'h03;
				3'h3:    selMask = 6'h07;
				3'h4:    selMask = 6'h0F;
				3'h5:    selMask = 6'h1F;
				3'h6:    selMask = 6'h3F;
				default: selMask = 6'h00;
			endcase
		end
	endfunction

	// ************************************************
	// Oscillators
	// ************************************************
	// crystal rate
	osc_tick #(.DIV(XTAL_DIV)) xtalOsc (
		.clk    (ref_clk),
		.rstN   (reset_n),
		.run    (xtalRun_r),
		.tick_r (xtalTick)
	);

	osc_tick #(.DIV(RC_DIV)) rcOsc (
		.clk    (ref_clk),
		.rstN   (reset_n),
		.run    (fastRun_r),
		.tick_r (rcTick)
	);

	osc_tick #(.DIV(SLOW_DIV)) slowOsc (
		.clk    (ref_clk),
		.rstN   (reset_n),
		.run    (slowRun_r),
		.tick_r (slowTick)
	);

	// ************************************************
	// Source selection
	// ************************************************
	assign tgtSel = sccReg_r[`SCC_SEL_MSB:`SCC_SEL_LSB];

	assign tgtSrc = sccReg_r[`SCC_SRC_BIT] & xtalRun_r;

	assign xtalEff = xtalTick & (~xtalReg_r[`XC_HALVE_BIT] | halfPh_r);

	assign rawFastCur = curSrc_r ? xtalEff : rcTick;
	assign rawFastTgt = tgtSrc ? xtalEff : rcTick;

	// sub clock from slow RC only
	assign subOn   = ~deepSleep & (~cpuHalt | sccReg_r[`SCC_SIDLE_BIT]);
	assign subTick = slowTick & subOn;

	assign curMask = selMask(curSel_r);
	assign sysTick = (curSel_r == `SEL_SUB) ? subTick :
	                 (rawFastCur & ((divCnt_r & curMask) == curMask));

	assign tgtRaw  = (tgtSel == `SEL_SUB) ? slowTick : rawFastTgt;
	assign curLost = (curSel_r != `SEL_SUB) & curSrc_r & ~xtalRun_r;
	assign adopt   = (state_r == ST_FILL) & tgtRaw;
	assign busy    = (state_r != ST_IDLE);

	// ************************************************
	// Oscillator enables
	// ************************************************
	// crystal needs both bits
	assign xtalRun_nxt = xtalReg_r[`XC_EN_BIT] & xtalReg_r[`XC_RADIO_BIT] & ~deepSleep;

	assign fastUse = cpuHalt ? sccReg_r[`SCC_FIDLE_BIT] :
	                 ((curSel_r != `SEL_SUB) | (tgtSel != `SEL_SUB) |
	                  xtalReg_r[`XC_FKEEP_BIT] | busy);

	assign fastRun_nxt = ~deepSleep & fastUse & (~curSrc_r | ~tgtSrc | busy);

	assign slowRun_nxt = wdtEnable | subOn;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xtalRun_r <= 1'b0;
			fastRun_r <= 1'b1;
			slowRun_r <= 1'b1;
		end else begin
			xtalRun_r <= xtalRun_nxt;
			fastRun_r <= fastRun_nxt;
			slowRun_r <= slowRun_nxt;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			halfPh_r <= 1'b0;
		end else if (!xtalRun_r) begin
			halfPh_r <= 1'b0;
		end else if (xtalTick) begin
			halfPh_r <= ~halfPh_r;
		end
	end

	// ************************************************
	// Switch sequencer
	// ************************************************
	// end current period, start on target edge
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if ((tgtSel != curSel_r) || (tgtSrc != curSrc_r)) begin
					state_nxt = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (sysTick || curLost) begin
					state_nxt = ST_FILL;
				end
			end
			ST_FILL: begin
				if (tgtRaw) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= ST_IDLE;
			curSel_r     <= 3'h1;
			curSrc_r     <= 1'b0;
			switchBusy_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			// Busy flag registered so the pin comes from a flop
			switchBusy_r <= (state_nxt != ST_IDLE);
			if (adopt) begin
				curSel_r <= tgtSel;
				curSrc_r <= tgtSrc;
			end
		end
	end

	// Restart divider so first divided period is whole
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_r <= 6'h00;
		end else if (adopt) begin
			divCnt_r <= 6'h00;
		end else if (rawFastCur) begin
			divCnt_r <= divCnt_r + 6'h01;
		end
	end

	// ************************************************
	// Clock enable outputs
	// ************************************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sysClkEn_r       <= 1'b0;
			fastClkEn_r      <= 1'b0;
			subClkEn_r       <= 1'b0;
			slowRcClkEn_r    <= 1'b0;
			radioClkEn_r     <= 1'b0;
			wdtClkEn_r       <= 1'b0;
			timeBase0ClkEn_r <= 1'b0;
		end else begin
			sysClkEn_r    <= sysTick & ~cpuHalt & (state_r != ST_FILL);
			fastClkEn_r   <= rawFastCur;
			subClkEn_r    <= subTick;
			slowRcClkEn_r <= slowTick;
			radioClkEn_r  <= xtalTick;
			// Watchdog has no function in deep sleep
			wdtClkEn_r    <= slowTick & wdtEnable & ~deepSleep;
			timeBase0ClkEn_r <= deepSleep ? (slowTick & wdtEnable) : rawFastCur;
		end
	end

	// ************************************************
	// Register port
	// ************************************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sccReg_r <= `SCC_RESET;
		end else if (regWrStrobe && (regAddr == `ADDR_SYS_CLK_CTRL)) begin
			sccReg_r <= regWrData & `SCC_WMASK;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xtalReg_r <= `XC_RESET;
		end else if (regWrStrobe && (regAddr == `ADDR_XTAL_CTRL)) begin
			xtalReg_r <= regWrData & `XC_WMASK;
		end
	end

	// Data valid only the cycle after the strobe
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_r <= 8'h00;
		end else if (regRdStrobe) begin
			case (regAddr)
				`ADDR_SYS_CLK_CTRL: rdData_r <= sccReg_r;
				`ADDR_XTAL_CTRL:    rdData_r <= xtalReg_r;
				`ADDR_CLK_STATUS:   rdData_r <= {curSrc_r, curSel_r, busy,
				                                 slowRun_r, fastRun_r, xtalRun_r};
				default:            rdData_r <= 8'h00;
			endcase
		end else begin
			rdData_r <= 8'h00;
		end
	end

	assign regRdData      = rdData_r;
	assign sysClkEn       = sysClkEn_r;
	assign fastClkEn      = fastClkEn_r;
	assign subClkEn       = subClkEn_r;
	assign slowRcClkEn    = slowRcClkEn_r;
	assign radioClkEn     = radioClkEn_r;
	assign wdtClkEn       = wdtClkEn_r;
	assign timeBase0ClkEn = timeBase0ClkEn_r;
	assign crystalOscRun  = xtalRun_r;
	assign fastRcOscRun   = fastRun_r;
	assign slowRcOscRun   = slowRun_r;
	assign clkSwitchBusy  = switchBusy_r;
endmodule

// >>> tb/system_clock_source_select_sva.sv
`timescale 1ns/100ps
module system_clock_source_select_sva (
	input wire       ref_clk,
	input wire       reset_n,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire       regWrStrobe,
	input wire       regRdStrobe,
	input wire [7:0] regRdData,
	input wire       deepSleep,
	input wire       wdtEnable,
	input wire       sysClkEn,
	input wire       fastClkEn,
	input wire       subClkEn,
	input wire       slowRcClkEn,
	input wire       radioClkEn,
	input wire       wdtClkEn,
	input wire       timeBase0ClkEn,
	input wire       crystalOscRun
);
	reg [1:0] xtalBits_r;

	// Shadow of crystal enable bits
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			xtalBits_r <= 2'h0;
		else if (regWrStrobe && regAddr == 8'h01)
			xtalBits_r <= regWrData[1:0];
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	rd_window_a: assert property (regRdData != 8'h00 |-> $past(regRdStrobe))
		else $error("read data outside its slot");
	xtal_gate_a: assert property (crystalOscRun |-> $past(xtalBits_r) == 2'h3 || $past(xtalBits_r, 2) == 2'h3)
		else $error("crystal running while not enabled");
	sub_src_a: assert property (subClkEn |-> slowRcClkEn)
		else $error("sub clock not from slow oscillator");
	wdt_clk_a: assert property (wdtClkEn |-> slowRcClkEn && $past(wdtEnable && !deepSleep))
		else $error("watchdog clock wrong");
	tb0_sleep_a: assert property (timeBase0ClkEn && $past(deepSleep) |-> slowRcClkEn && $past(wdtEnable))
		else $error("time base clock wrong in deep sleep");
	tb0_fast_a: assert property (timeBase0ClkEn && !$past(deepSleep) |-> fastClkEn)
		else $error("time base clock wrong when awake");
	radio_xtal_a: assert property (radioClkEn |-> $past(crystalOscRun, 2))
		else $error("radio clock without crystal");
	sys_source_a: assert property (sysClkEn |-> fastClkEn || slowRcClkEn)
		else $error("system pulse from no source");
	sys_spacing_a: assert property (sysClkEn |=> !sysClkEn [*4])
		else $error("system clock pulse truncated");
endmodule

bind system_clock_source_select system_clock_source_select_sva i_sva (
	.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
	.deepSleep(deepSleep), .wdtEnable(wdtEnable), .sysClkEn(sysClkEn), .fastClkEn(fastClkEn),
	.subClkEn(subClkEn), .slowRcClkEn(slowRcClkEn), .radioClkEn(radioClkEn), .wdtClkEn(wdtClkEn),
	.timeBase0ClkEn(timeBase0ClkEn), .crystalOscRun(crystalOscRun)
);

// >>> tb/system_clock_source_select_tb.sv
`timescale 1ns/100ps
module system_clock_source_select_tb;
	logic       ref_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic       regWrStrobe = 1'b0;
	logic       regRdStrobe = 1'b0;
	logic       cpuHalt = 1'b0;
	logic       deepSleep = 1'b0;
	logic       wdtEnable = 1'b0;
	wire  [7:0] regRdData;
	wire  [6:0] pulse;
	wire        xtalRun;
	wire        rcRun;
	wire        slowRun;
	wire        busy;
	int         errors = 0;
	int         checksDone = 0;
	logic [7:0] d;
	int         n;

	system_clock_source_select i_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.cpuHalt(cpuHalt), .deepSleep(deepSleep), .wdtEnable(wdtEnable), .sysClkEn(pulse[0]),
		.fastClkEn(pulse[1]), .radioClkEn(pulse[2]), .subClkEn(pulse[3]), .wdtClkEn(pulse[4]),
		.timeBase0ClkEn(pulse[5]), .slowRcClkEn(pulse[6]), .crystalOscRun(xtalRun),
		.fastRcOscRun(rcRun), .slowRcOscRun(slowRun), .clkSwitchBusy(busy)
	);

	always #5 ref_clk = ~ref_clk;

	// ****************
	// Helpers
	// ****************
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		#1 v = regRdData;
	endtask

	// Busy rises one edge after a clock select write, two after a crystal write, so look only after that
	task settle;
		int i;
		repeat (4) @(posedge ref_clk);
		#1;
		for (i = 0; i < 8000 && busy !== 1'b0; i++) @(posedge ref_clk) #1;
		check("switchDone", busy, 1'b0);
	endtask

	// Cycles between two pulses; the first pulse after the call starts the count
	task gap(input int k, input int lim, output int cnt);
		int i;
		cnt = 0;
		@(posedge ref_clk) #1;
		for (i = 0; i < lim && pulse[k] !== 1'b1; i++) @(posedge ref_clk) #1;
		if (pulse[k] === 1'b1) begin
			cnt = 1;
			@(posedge ref_clk) #1;
			while (cnt < lim && pulse[k] !== 1'b1) begin
				cnt++;
				@(posedge ref_clk) #1;
			end
			if (pulse[k] !== 1'b1) cnt = 0;
		end
	endtask

	task summarize;
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_reset;
		rd(8'h00, d);
		check("ctrlReset", d, 8'h20);
		rd(8'h01, d);
		check("xtalReset", d, 8'h00);
		rd(8'h02, d);
		check("statusReset", d, 8'h16);
		check("slowRunReset", slowRun, 1'b1);
		rd(8'h55, d);
		check("unmapped", d, 8'h00);
	endtask

	task t_div;
		int i;
		for (i = 0; i < 7; i++) begin
			wr(8'h00, {i[2:0], 5'h00});
			settle;
			gap(0, 2000, n);
			check("sysGapRc", n, 12 << i);
		end
	endtask

	task t_xtal;
		wr(8'h00, 8'h08);
		wr(8'h01, 8'h01);
		settle;
		check("xtalHalfOn", xtalRun, 1'b0);
		gap(0, 200, n);
		check("sysGapFallback", n, 12);
		wr(8'h01, 8'h03);
		settle;
		check("xtalOn", xtalRun, 1'b1);
		gap(0, 200, n);
		check("sysGapXtal", n, 6);
		gap(2, 200, n);
		check("radioGap", n, 6);
		wr(8'h01, 8'h07);
		settle;
		gap(0, 200, n);
		check("sysGapHalved", n, 12);
		gap(2, 200, n);
		check("radioGapHalved", n, 6);
		wr(8'h01, 8'h00);
		settle;
		gap(0, 200, n);
		check("sysGapXtalOff", n, 12);
	endtask

	task t_sub;
		wr(8'h00, 8'hE0);
		settle;
		gap(3, 8000, n);
		check("subGap", n, 3125);
		gap(0, 8000, n);
		check("sysGapSub", n, 3125);
		check("fastStopped", rcRun, 1'b0);
		rd(8'h02, d);
		check("appliedSel", d[6:4], 3'h7);
		wr(8'h01, 8'h08);
		repeat (4) @(posedge ref_clk);
		check("fastKept", rcRun, 1'b1);
		wr(8'h01, 8'h00);
	endtask

	task t_halt;
		wr(8'h00, 8'h00);
		settle;
		@(posedge ref_clk);
		cpuHalt <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("haltFastOff", rcRun, 1'b0);
		wr(8'h00, 8'h02);
		repeat (4) @(posedge ref_clk);
		check("haltFastOn", rcRun, 1'b1);
		cpuHalt <= 1'b0;
	endtask

	task t_sleep;
		@(posedge ref_clk);
		wdtEnable <= 1'b1;
		gap(4, 8000, n);
		check("wdtGap", n, 3125);
		@(posedge ref_clk);
		deepSleep <= 1'b1;
		gap(5, 8000, n);
		check("tb0Sleep", n, 3125);
		check("slowRunWdt", slowRun, 1'b1);
		@(posedge ref_clk);
		wdtEnable <= 1'b0;
		gap(5, 3300, n);
		check("tb0NoWdt", n, 0);
		check("slowRunOff", slowRun, 1'b0);
		@(posedge ref_clk);
		deepSleep <= 1'b0;
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset;
		t_div;
		t_xtal;
		t_sub;
		t_halt;
		t_sleep;
		summarize;
	end

	// Whole run is well under 60000 cycles
	initial begin
		#600_000;
		errors++;
		summarize;
	end
endmodule
